// ### hw/puias_pkg.sv
// shared constants and types for the power-up init and address select block
package puias_pkg;
  // data widths
  localparam int CFG_W = 8; // width of one working register
  localparam int ADDR_W = 7; // bus address width
  localparam int ADC_W = 10; // strap converter resolution
  localparam int OFS_W = 4; // address offset width
  localparam int NUM_OFS = 16; // number of strap offset ranges
  // working register layout
  localparam int NVM_WORDS = 8; // words copied from the nonvolatile store
  localparam int IDX_TWI_BASE = 0; // twi base address register
  localparam int IDX_PM_BASE = 1; // pm link base address register
  localparam int IDX_EN_CFG = 2; // software enable configuration
  localparam int EN_CFG_OVR_BIT = 0; // software enable overrides the pins
  localparam int EN_CFG_ON_BIT = 1; // software enable request
  // reset values of the base addresses
  localparam logic [ADDR_W-1:0] TWI_BASE_RST = 7'h10;
  localparam logic [ADDR_W-1:0] PM_BASE_RST = 7'h40;
  // strap decode: width of each converter range
  localparam int STRAP_STEP = 60;
  // timing
  localparam int CLK_FREQ_HZ = 50_000_000; // system clock rate
  localparam int SS_TIME_US = 2000; // soft-start ramp length in us
  localparam int SS_CYCLES = SS_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  // sequencer states
  typedef enum logic [2:0] {
    ST_POR,
    ST_LOAD_REQ,
    ST_LOAD_WAIT,
    ST_ADC_REQ,
    ST_ADC_WAIT,
    ST_RUN
  } puias_state_t;
endpackage

// ### hw/puias_strap_decode.sv
// strap converter code to address offset and floating flag
`timescale 1ns/10ps
module puias_strap_decode #(
  parameter int ADC_W = puias_pkg::ADC_W,
  parameter int OFS_W = puias_pkg::OFS_W,
  parameter int NUM_OFS = puias_pkg::NUM_OFS,
  parameter int STEP = puias_pkg::STRAP_STEP
) (
  // converter result
  input wire logic [ADC_W-1:0] code_i,
  // decoded result
  output logic [OFS_W-1:0] offset_o,
  output logic float_o
);
  logic [NUM_OFS-1:0] above; // code lies past the top of range i

  // one comparator per range bound
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OFS; gi = gi + 1) begin : g_bound
      localparam logic [ADC_W:0] BOUND = (ADC_W + 1)'((gi + 1) * STEP - 1);
      assign above[gi] = {1'b0, code_i} > BOUND;
    end
  endgenerate

  // monotonic: offset counts the ranges passed, past the last is floating
  always_comb begin
    offset_o = '0;
    for (int i = 0; i < NUM_OFS - 1; i++) begin
      if (above[i]) begin
        offset_o = OFS_W'(i + 1);
      end
    end
    float_o = above[NUM_OFS-1];
  end
endmodule

// ### hw/puias_top.sv
// power-up sequencer, config load, strap address select and conversion gating
`timescale 1ns/10ps
// What this block does
// - hold reset until supplies and oscillator ready
// - after reset copy nonvolatile store to registers
// - accept bus writes after load and strap read in digital mode, any enable
// - default start needs enable, input, load, address
// - software enable overrides pins in digital mode
// - two seven-bit base address registers
// - zero base address mutes that bus
// - address is base plus strap offset
// - strap picks one of sixteen offsets
// - strap converted once during initialization
// - offsets rise monotonically with strap reading
// - digital mode answers at computed address
// - floating strap silences all bus traffic
// - analog mode repurposes pins, config frozen
// - soft-start begins only after conversion enabled
module puias_top #(
  parameter int NVM_WORDS = puias_pkg::NVM_WORDS,
  parameter int SS_CYCLES = puias_pkg::SS_CYCLES,
  parameter int IDX_W = $clog2(NVM_WORDS)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // analog monitors, asynchronous
  input wire logic vcc_ok_i,
  input wire logic core_supply_rail_ok_i,
  input wire logic osc_stable_i,
  input wire logic enable_forced_ccm_pin_i,
  input wire logic pvin_ok_i,
  // nonvolatile config store read port
  output logic nvm_rd_o,
  output logic [IDX_W-1:0] nvm_addr_o,
  input wire logic nvm_rvalid_i,
  input wire logic [puias_pkg::CFG_W-1:0] nvm_rdata_i,
  // strap converter
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [puias_pkg::ADC_W-1:0] adc_data_i,
  // command port from the serial bus engine
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic cmd_pm_i,
  input wire logic [puias_pkg::ADDR_W-1:0] cmd_dev_i,
  input wire logic [IDX_W-1:0] cmd_idx_i,
  input wire logic [puias_pkg::CFG_W-1:0] cmd_wdata_i,
  output logic cmd_ack_o,
  output logic [puias_pkg::CFG_W-1:0] cmd_rdata_o,
  // status and control
  output logic por_n_o,
  output logic load_done_o,
  output logic addr_read_o,
  output logic digital_mode_o,
  output logic analog_pins_o,
  output logic [puias_pkg::OFS_W-1:0] offset_o,
  output logic [puias_pkg::ADDR_W-1:0] twi_addr_o,
  output logic [puias_pkg::ADDR_W-1:0] pm_addr_o,
  output logic twi_on_o,
  output logic pm_on_o,
  output logic conv_en_o,
  output logic ss_ramp_o
);
  localparam int SS_W = $clog2(SS_CYCLES + 1);
  localparam int CW = puias_pkg::CFG_W;
  localparam int AW = puias_pkg::ADDR_W;
  // two-flop synchronisers for the monitor inputs
  logic [4:0] sync_a; // first stage, read only by sync_b
  logic [4:0] sync_b; // second stage, safe to use
  logic [4:0] pins_raw;
  logic sup_ok; // supplies and oscillator good
  logic en_pin; // enable pin above threshold
  logic pvin_on; // input bus above threshold

  assign pins_raw = {pvin_ok_i, enable_forced_ccm_pin_i, osc_stable_i, core_supply_rail_ok_i, vcc_ok_i};
  assign sup_ok = &sync_b[2:0];
  assign en_pin = sync_b[3];
  assign pvin_on = sync_b[4];
  // synchroniser chain
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  // strap decoder
  logic [puias_pkg::OFS_W-1:0] dec_offset;
  logic dec_float;

  puias_strap_decode u_decode (
    .code_i(adc_data_i),
    .offset_o(dec_offset),
    .float_o(dec_float)
  );
  // address match: muted when base is zero
  function automatic logic bus_hit(input logic [AW-1:0] base, input logic [AW-1:0] dev,
                                   input logic [puias_pkg::OFS_W-1:0] ofs);
    logic [AW-1:0] full;
    full = AW'(base + {3'h0, ofs});
    bus_hit = (base != '0) && (dev == full);
  endfunction
  // sequencer and latched strap state
  puias_pkg::puias_state_t state, next_state;
  logic [IDX_W-1:0] load_idx, next_load_idx;
  logic [puias_pkg::OFS_W-1:0] next_offset;
  logic next_digital, next_addr_read, next_load_done;
  logic next_nvm_rd, next_adc_start;

  // sequencer next values
  always_comb begin
    next_state = state;
    next_load_idx = load_idx;
    next_offset = offset_o;
    next_digital = digital_mode_o;
    next_addr_read = addr_read_o;
    next_load_done = load_done_o;
    next_nvm_rd = 1'b0;
    next_adc_start = 1'b0;
    case (state)
      // hold internal reset while monitors are low
      puias_pkg::ST_POR: begin
        next_load_idx = '0;
        if (sup_ok) begin
          next_state = puias_pkg::ST_LOAD_REQ;
        end
      end
      // request one word from the store
      puias_pkg::ST_LOAD_REQ: begin
        next_nvm_rd = 1'b1;
        next_state = puias_pkg::ST_LOAD_WAIT;
      end
      // wait for word, step to next or to the strap read
      puias_pkg::ST_LOAD_WAIT: begin
        if (nvm_rvalid_i) begin
          if (load_idx == IDX_W'(NVM_WORDS - 1)) begin
            next_load_done = 1'b1;
            next_state = puias_pkg::ST_ADC_REQ;
          end else begin
            next_load_idx = IDX_W'(load_idx + 1'b1);
            next_state = puias_pkg::ST_LOAD_REQ;
          end
        end
      end
      // single strap conversion
      puias_pkg::ST_ADC_REQ: begin
        next_adc_start = 1'b1;
        next_state = puias_pkg::ST_ADC_WAIT;
      end
      // latch offset and mode once
      puias_pkg::ST_ADC_WAIT: begin
        if (adc_done_i) begin
          next_offset = dec_float ? '0 : dec_offset;
          next_digital = !dec_float;
          next_addr_read = 1'b1;
          next_state = puias_pkg::ST_RUN;
        end
      end
      // stay until reset; supply loss reinitialises
      puias_pkg::ST_RUN: begin
        if (!sup_ok) begin
          next_state = puias_pkg::ST_POR;
          next_load_done = 1'b0;
          next_addr_read = 1'b0;
          next_digital = 1'b0;
          next_offset = '0;
        end
      end
      default: begin
        next_state = puias_pkg::ST_POR;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= puias_pkg::ST_POR;
      load_idx <= '0;
      offset_o <= '0;
      digital_mode_o <= 1'b0;
      addr_read_o <= 1'b0;
      load_done_o <= 1'b0;
      nvm_rd_o <= 1'b0;
      nvm_addr_o <= '0;
      adc_start_o <= 1'b0;
    end else begin
      state <= next_state;
      load_idx <= next_load_idx;
      offset_o <= next_offset;
      digital_mode_o <= next_digital;
      addr_read_o <= next_addr_read;
      load_done_o <= next_load_done;
      nvm_rd_o <= next_nvm_rd;
      nvm_addr_o <= next_load_idx;
      adc_start_o <= next_adc_start;
    end
  end

  // working registers and command port
  logic [CW-1:0] cfg [NVM_WORDS];
  logic [CW-1:0] next_cfg [NVM_WORDS];
  logic cmd_hit; // command addressed to this device
  logic cmd_open; // writes and reads allowed
  logic next_ack;
  logic [CW-1:0] next_rdata;
  logic [AW-1:0] twi_base, pm_base;

  assign twi_base = cfg[puias_pkg::IDX_TWI_BASE][AW-1:0];
  assign pm_base = cfg[puias_pkg::IDX_PM_BASE][AW-1:0];
  assign cmd_hit = cmd_pm_i ? bus_hit(pm_base, cmd_dev_i, offset_o) : bus_hit(twi_base, cmd_dev_i, offset_o);
  assign cmd_open = (state == puias_pkg::ST_RUN) && digital_mode_o;

  // load copies, bus writes rewrite, base registers keep seven bits
  always_comb begin
    for (int i = 0; i < NVM_WORDS; i++) begin
      next_cfg[i] = cfg[i];
    end
    next_ack = 1'b0;
    next_rdata = cmd_rdata_o;
    if (state == puias_pkg::ST_LOAD_WAIT && nvm_rvalid_i) begin
      next_cfg[load_idx] = nvm_rdata_i;
    end else if (cmd_open && cmd_hit && cmd_wr_i) begin
      next_cfg[cmd_idx_i] = cmd_wdata_i;
      next_ack = 1'b1;
    end else if (cmd_open && cmd_hit && cmd_rd_i) begin
      next_rdata = cfg[cmd_idx_i];
      next_ack = 1'b1;
    end
    next_cfg[puias_pkg::IDX_TWI_BASE][CW-1] = 1'b0;
    next_cfg[puias_pkg::IDX_PM_BASE][CW-1] = 1'b0;
  end

  // working register storage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NVM_WORDS; i++) begin
        cfg[i] <= '0;
      end
      cfg[puias_pkg::IDX_TWI_BASE] <= {1'b0, puias_pkg::TWI_BASE_RST};
      cfg[puias_pkg::IDX_PM_BASE] <= {1'b0, puias_pkg::PM_BASE_RST};
      cmd_ack_o <= 1'b0;
      cmd_rdata_o <= '0;
    end else begin
      for (int i = 0; i < NVM_WORDS; i++) begin
        cfg[i] <= next_cfg[i];
      end
      cmd_ack_o <= next_ack;
      cmd_rdata_o <= next_rdata;
    end
  end

  // addresses, enables, soft-start
  logic sw_ovr, sw_on, dflt_en;
  logic next_conv, next_ss, next_twi_on, next_pm_on, next_por_n, next_analog;
  logic [AW-1:0] next_twi_addr, next_pm_addr;
  logic [SS_W-1:0] ss_cnt, next_ss_cnt;

  assign sw_ovr = cfg[puias_pkg::IDX_EN_CFG][puias_pkg::EN_CFG_OVR_BIT];
  assign sw_on = cfg[puias_pkg::IDX_EN_CFG][puias_pkg::EN_CFG_ON_BIT];
  assign dflt_en = en_pin && pvin_on && load_done_o && addr_read_o;

  // output next values
  always_comb begin
    next_por_n = (state != puias_pkg::ST_POR);
    next_analog = addr_read_o && !digital_mode_o;
    next_twi_addr = AW'(twi_base + {3'h0, offset_o});
    next_pm_addr = AW'(pm_base + {3'h0, offset_o});
    next_twi_on = cmd_open && (twi_base != '0);
    next_pm_on = cmd_open && (pm_base != '0);
    if (digital_mode_o && sw_ovr) begin
      next_conv = sw_on && load_done_o && addr_read_o;
    end else begin
      next_conv = dflt_en;
    end
    // ramp runs from the cycle after enable, restarts on each enable
    next_ss_cnt = ss_cnt;
    next_ss = 1'b0;
    if (!conv_en_o) begin
      next_ss_cnt = '0;
    end else if (ss_cnt != SS_W'(SS_CYCLES)) begin
      next_ss_cnt = SS_W'(ss_cnt + 1'b1);
      next_ss = 1'b1;
    end
  end

  // output registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      por_n_o <= 1'b0;
      analog_pins_o <= 1'b0;
      twi_addr_o <= '0;
      pm_addr_o <= '0;
      twi_on_o <= 1'b0;
      pm_on_o <= 1'b0;
      conv_en_o <= 1'b0;
      ss_ramp_o <= 1'b0;
      ss_cnt <= '0;
    end else begin
      por_n_o <= next_por_n;
      analog_pins_o <= next_analog;
      twi_addr_o <= next_twi_addr;
      pm_addr_o <= next_pm_addr;
      twi_on_o <= next_twi_on;
      pm_on_o <= next_pm_on;
      conv_en_o <= next_conv;
      ss_ramp_o <= next_ss;
      ss_cnt <= next_ss_cnt;
    end
  end

  // checks
  chk_por_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    !sup_ok && state == puias_pkg::ST_POR |=> !por_n_o) else $error("reset released before monitors good");
  chk_load_copy: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(load_done_o) |-> $past(nvm_rvalid_i) && $past(state == puias_pkg::ST_LOAD_WAIT))
    else $error("load end without word");
  chk_cmd_accept: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_open && cmd_hit && cmd_wr_i |=> cmd_ack_o) else $error("valid write not taken");
  chk_conv_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(conv_en_o) |-> $past(load_done_o && addr_read_o)) else $error("conversion before init");
  chk_sw_override: assert property (@(posedge clk_i) disable iff (srst_i)
    digital_mode_o && sw_ovr && !sw_on |=> !conv_en_o) else $error("override off ignored");
  chk_zero_base: assert property (@(posedge clk_i) disable iff (srst_i)
    twi_base == '0 && $stable(twi_base) |=> !twi_on_o) else $error("zero base still on");
  chk_addr_sum: assert property (@(posedge clk_i) disable iff (srst_i)
    addr_read_o |=> twi_addr_o == AW'($past(twi_base) + {3'h0, $past(offset_o)}))
    else $error("address not base plus offset");
  chk_float_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    addr_read_o && !digital_mode_o |=> !cmd_ack_o ##1 !cmd_ack_o) else $error("analog mode answered bus");
  chk_offset_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    addr_read_o && $past(addr_read_o) |-> $stable(offset_o) && $stable(digital_mode_o)) else $error("strap reevaluated");
  chk_ss_after: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(ss_ramp_o) |-> $past(conv_en_o) && conv_en_o) else $error("ramp before enable");
endmodule

// ### sim/puias_store_model.sv
// config store and strap converter responder model
`timescale 1ns/10ps
module puias_store_model #(
  parameter int ADC_DLY = 3
) (
  // clock
  input wire logic clk_i,
  // store read port
  input wire logic nvm_rd_i,
  input wire logic [2:0] nvm_addr_i,
  output logic nvm_rvalid_o,
  output logic [7:0] nvm_rdata_o,
  // strap converter
  input wire logic adc_start_i,
  input wire logic [9:0] code_i,
  output logic adc_done_o,
  output logic [9:0] adc_data_o
);
  logic [7:0] mem [8]; // stored image
  logic [2:0] a; // word being read
  initial begin
    mem = '{8'h10, 8'h40, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h00};
    nvm_rvalid_o = 1'b0;
    nvm_rdata_o = 8'h00;
    adc_done_o = 1'b0;
    adc_data_o = 10'h000;
  end
  // word read: even words quick, odd words slow
  always begin
    @(negedge clk_i);
    if (nvm_rd_i === 1'b1) begin
      a = nvm_addr_i;
      repeat (a[0] ? 4 : 1) @(posedge clk_i);
      #1 nvm_rvalid_o = 1'b1;
      nvm_rdata_o = mem[a];
      @(posedge clk_i);
      #1 nvm_rvalid_o = 1'b0;
      nvm_rdata_o = ~nvm_rdata_o; // stale data is not held
    end
  end
  // strap conversion after a fixed latency
  always begin
    @(negedge clk_i);
    if (adc_start_i === 1'b1) begin
      repeat (ADC_DLY) @(posedge clk_i);
      #1 adc_done_o = 1'b1;
      adc_data_o = code_i;
      @(posedge clk_i);
      #1 adc_done_o = 1'b0;
      adc_data_o = ~code_i; // result not held
    end
  end
endmodule

// ### sim/puias_top_tb.sv
// self-checking bench for the power-up init and address select block
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module puias_top_tb;
  logic clk_i = 1'b0, srst_i = 1'b1, en_pin = 1'b0, pvin = 1'b0; // clock, reset, pins
  logic [2:0] mon = 3'b000; // supply and oscillator monitors
  logic cmd_wr = 1'b0, cmd_rd = 1'b0, cmd_pm = 1'b0; // command strobes
  logic [6:0] cmd_dev = 7'h00; // addressed device
  logic [2:0] cmd_idx = 3'h0; // register index
  logic [7:0] cmd_wd = 8'h00; // write data
  logic [9:0] code = 10'h000; // strap reading
  logic nvm_rd, nvm_rvalid, adc_start, adc_done, ack, por_n, load_done, addr_read, dig, ana;
  logic twi_on, pm_on, conv, ramp;
  logic [2:0] nvm_addr;
  logic [7:0] nvm_rdata, rdata;
  logic [9:0] adc_data;
  logic [3:0] offset;
  logic [6:0] twi_addr, pm_addr;
  int fail_count = 0, compares = 0, starts = 0;
  initial forever #10 clk_i = ~clk_i;
  puias_top #(.SS_CYCLES(20)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .vcc_ok_i(mon[0]),
    .core_supply_rail_ok_i(mon[1]), .osc_stable_i(mon[2]), .enable_forced_ccm_pin_i(en_pin),
    .pvin_ok_i(pvin), .nvm_rd_o(nvm_rd), .nvm_addr_o(nvm_addr), .nvm_rvalid_i(nvm_rvalid),
    .nvm_rdata_i(nvm_rdata), .adc_start_o(adc_start), .adc_done_i(adc_done), .adc_data_i(adc_data),
    .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_pm_i(cmd_pm), .cmd_dev_i(cmd_dev), .cmd_idx_i(cmd_idx),
    .cmd_wdata_i(cmd_wd), .cmd_ack_o(ack), .cmd_rdata_o(rdata), .por_n_o(por_n),
    .load_done_o(load_done), .addr_read_o(addr_read), .digital_mode_o(dig), .analog_pins_o(ana),
    .offset_o(offset), .twi_addr_o(twi_addr), .pm_addr_o(pm_addr), .twi_on_o(twi_on),
    .pm_on_o(pm_on), .conv_en_o(conv), .ss_ramp_o(ramp));
  puias_store_model #(.ADC_DLY(3)) store_u (.clk_i(clk_i), .nvm_rd_i(nvm_rd), .nvm_addr_i(nvm_addr),
    .nvm_rvalid_o(nvm_rvalid), .nvm_rdata_o(nvm_rdata), .adc_start_i(adc_start), .code_i(code),
    .adc_done_o(adc_done), .adc_data_o(adc_data));
  // count strap conversions
  always @(posedge clk_i) if (adc_start === 1'b1) starts++;
  // reset, power up and wait for the strap to be read
  task automatic init(input logic [9:0] c);
    int n;
    code = c;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 srst_i = 1'b0;
    mon = 3'b111;
    starts = 0;
    n = 0;
    while (addr_read !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #1 n++;
    end
    `CHK("addr_read", 1'b1, addr_read)
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // one command cycle, ack checked the cycle after
  task automatic cmd(input logic wr, pm, input logic [6:0] dev, input logic [2:0] idx,
                     input logic [7:0] d, input logic ak);
    cmd_wr = wr;
    cmd_rd = !wr;
    cmd_pm = pm;
    cmd_dev = dev;
    cmd_idx = idx;
    cmd_wd = d;
    @(posedge clk_i);
    #1 cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    `CHK("ack", ak, ack)
    wait_n(1); // idle edge so the next call never flips a strobe twice in one step
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #400_000;
    fail_count++;
    test_done;
  end
  // main sequence
  initial begin
    wait_n(2);
    srst_i = 1'b0;
    mon = 3'b011; // oscillator not yet stable
    wait_n(12);
    `CHK("por_n", 1'b0, por_n)
    `CHK("load_done", 1'b0, load_done)
    $display("test por_hold done");
    for (int i = 0; i < 16; i++) begin
      init(10'(i * 60 + 59)); // top edge of each range
      `CHK("offset", 4'(i), offset)
      `CHK("twi_addr", 7'(16 + i), twi_addr)
      `CHK("pm_addr", 7'(64 + i), pm_addr)
    end
    $display("test strap_sweep done");
    init(10'h082); // offset 2
    `CHK("conversions", 1, starts)
    `CHK("load_done", 1'b1, load_done)
    `CHK("digital", 1'b1, dig)
    `CHK("pm_on", 1'b1, pm_on)
    `CHK("por_n", 1'b1, por_n)
    `CHK("twi_on", 1'b1, twi_on)
    cmd(1'b1, 1'b0, 7'h12, 3'h3, 8'ha5, 1'b1);
    cmd(1'b0, 1'b0, 7'h12, 3'h3, 8'h00, 1'b1);
    `CHK("rdata", 8'ha5, rdata)
    cmd(1'b0, 1'b1, 7'h42, 3'h4, 8'h00, 1'b1);
    `CHK("rdata", 8'h3c, rdata)
    cmd(1'b1, 1'b0, 7'h13, 3'h3, 8'h11, 1'b0);
    cmd(1'b0, 1'b0, 7'h12, 3'h3, 8'h00, 1'b1);
    `CHK("rdata", 8'ha5, rdata)
    cmd(1'b1, 1'b1, 7'h42, 3'h1, 8'h00, 1'b1);
    wait_n(2);
    `CHK("pm_on", 1'b0, pm_on)
    cmd(1'b0, 1'b1, 7'h42, 3'h1, 8'h00, 1'b0);
    cmd(1'b0, 1'b1, 7'h02, 3'h1, 8'h00, 1'b0);
    cmd(1'b1, 1'b0, 7'h12, 3'h0, 8'hff, 1'b1);
    wait_n(2);
    `CHK("twi_addr", 7'h01, twi_addr)
    cmd(1'b1, 1'b0, 7'h01, 3'h0, 8'h20, 1'b1);
    wait_n(2);
    `CHK("twi_addr", 7'h22, twi_addr)
    $display("test bus_access done");
    en_pin = 1'b1;
    wait_n(6);
    `CHK("conv_en", 1'b0, conv)
    pvin = 1'b1;
    wait_n(6);
    `CHK("conv_en", 1'b1, conv)
    `CHK("ss_ramp", 1'b1, ramp)
    wait_n(24);
    `CHK("ss_ramp", 1'b0, ramp)
    cmd(1'b1, 1'b0, 7'h22, 3'h2, 8'h01, 1'b1);
    wait_n(3);
    `CHK("conv_en", 1'b0, conv)
    cmd(1'b1, 1'b0, 7'h22, 3'h2, 8'h03, 1'b1);
    en_pin = 1'b0;
    wait_n(6);
    `CHK("conv_en", 1'b1, conv)
    $display("test conv_gate done");
    en_pin = 1'b1;
    init(10'h3c0); // just past the top range
    `CHK("digital", 1'b0, dig)
    `CHK("analog_pins", 1'b1, ana)
    `CHK("twi_on", 1'b0, twi_on)
    cmd(1'b1, 1'b0, 7'h10, 3'h2, 8'h01, 1'b0);
    cmd(1'b1, 1'b1, 7'h40, 3'h2, 8'h01, 1'b0);
    code = 10'h000;
    wait_n(20);
    `CHK("digital", 1'b0, dig)
    `CHK("conv_en", 1'b1, conv)
    `CHK("conversions", 1, starts)
    mon = 3'b011; // oscillator lost while running
    wait_n(6);
    `CHK("por_n", 1'b0, por_n)
    `CHK("load_done", 1'b0, load_done)
    `CHK("conv_en", 1'b0, conv)
    $display("test analog_mode done");
    test_done;
  end
endmodule
